//--- tap_controller.sv
module tap_controller
  import tap_pkg::*;
#(
  parameter int IRW = IR_WIDTH,
  parameter int BSRW = BSR_WIDTH
) (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic tck, // Test clock pin
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data in pin
  input wire logic trst_n, // Test reset pin, active low
  input wire logic [BSRW-1:0] sys_in, // System logic values at the boundary
  output logic [BSRW-1:0] pin_out, // Values presented at the boundary pins
  output logic tdo, // Test data out
  output logic tdo_oe, // Test data out enable
  output logic [IRW-1:0] cur_insn, // Current instruction
  output logic test_active // Boundary cells drive pins
);

  localparam logic [IRW-1:0] IR_CAP = IRW'(IR_CAPTURE);
  localparam logic [IRW-1:0] IR_DEF = IRW'(INSN_DEFAULT);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic tck_prev;
    tap_state_t state;
    logic [IRW-1:0] ir_shift;
    logic [IRW-1:0] ir_latch;
    logic bypass;
    logic [31:0] id_shift;
    logic [BSRW-1:0] bsr_shift;
    logic [BSRW-1:0] bsr_latch;
    logic [BSRW-1:0] pin_out;
    logic tdo;
    logic tdo_oe;
    logic test_active;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  tap_pins_t pins_raw;
  tap_pins_t pins;
  logic rst_local_n;
  logic tck_rise;
  logic tck_fall;
  logic sel_bypass;
  logic sel_id;
  logic sel_bsr;
  logic dr_out;

  initial begin
    if (IRW < 2) $error("Instruction register needs two or more cells");
    if (IRW > 32 || BSRW < 1) $error("Unsupported register width");
  end

  assign rst_local_n = st.rst_sync[1];
  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

  tap_sync #(
    .WIDTH($bits(tap_pins_t))
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_local_n),
    .din(pins_raw),
    .dout(pins)
  );

  // Edges of the sampled test clock
  assign tck_rise = pins.tck && !st.tck_prev;
  assign tck_fall = !pins.tck && st.tck_prev;

  // Data register selection from the current instruction
  always_comb begin
    sel_bsr = (st.ir_latch == IRW'(INSN_EXTEST)) || (st.ir_latch == IRW'(INSN_SAMPLE));
    sel_id = (st.ir_latch == IRW'(INSN_IDCODE));
    sel_bypass = !sel_bsr && !sel_id;
    if (sel_bsr) begin
      dr_out = st.bsr_shift[0];
    end else if (sel_id) begin
      dr_out = st.id_shift[0];
    end else begin
      dr_out = st.bypass;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], 1'b1};
    next_st.tck_prev = pins.tck;

    if (!pins.trst_n) begin
      next_st.state = ST_RESET;
      next_st.ir_latch = IR_DEF;
    end else if (tck_rise) begin
      // Next state from TMS only, on test clock rise
      unique case (st.state)
        ST_RESET: begin
          if (pins.tms) begin
            next_st.state = ST_RESET;
          end else begin
            next_st.state = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (pins.tms) begin
            next_st.state = ST_SEL_DR;
          end else begin
            next_st.state = ST_IDLE;
          end
        end
        ST_SEL_DR: begin
          if (pins.tms) begin
            next_st.state = ST_SEL_IR;
          end else begin
            next_st.state = ST_CAP_DR;
          end
        end
        ST_CAP_DR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT1_DR;
          end else begin
            next_st.state = ST_SHIFT_DR;
          end
        end
        ST_SHIFT_DR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT1_DR;
          end else begin
            next_st.state = ST_SHIFT_DR;
          end
        end
        ST_EXIT1_DR: begin
          if (pins.tms) begin
            next_st.state = ST_UPD_DR;
          end else begin
            next_st.state = ST_PAUSE_DR;
          end
        end
        ST_PAUSE_DR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT2_DR;
          end else begin
            next_st.state = ST_PAUSE_DR;
          end
        end
        ST_EXIT2_DR: begin
          if (pins.tms) begin
            next_st.state = ST_UPD_DR;
          end else begin
            next_st.state = ST_SHIFT_DR;
          end
        end
        ST_UPD_DR: begin
          if (pins.tms) begin
            next_st.state = ST_SEL_DR;
          end else begin
            next_st.state = ST_IDLE;
          end
        end
        ST_SEL_IR: begin
          if (pins.tms) begin
            next_st.state = ST_RESET;
          end else begin
            next_st.state = ST_CAP_IR;
          end
        end
        ST_CAP_IR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT1_IR;
          end else begin
            next_st.state = ST_SHIFT_IR;
          end
        end
        ST_SHIFT_IR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT1_IR;
          end else begin
            next_st.state = ST_SHIFT_IR;
          end
        end
        ST_EXIT1_IR: begin
          if (pins.tms) begin
            next_st.state = ST_UPD_IR;
          end else begin
            next_st.state = ST_PAUSE_IR;
          end
        end
        ST_PAUSE_IR: begin
          if (pins.tms) begin
            next_st.state = ST_EXIT2_IR;
          end else begin
            next_st.state = ST_PAUSE_IR;
          end
        end
        ST_EXIT2_IR: begin
          if (pins.tms) begin
            next_st.state = ST_UPD_IR;
          end else begin
            next_st.state = ST_SHIFT_IR;
          end
        end
        ST_UPD_IR: begin
          if (pins.tms) begin
            next_st.state = ST_SEL_DR;
          end else begin
            next_st.state = ST_IDLE;
          end
        end
      endcase

      // Register actions in the state being left
      unique case (st.state)
        ST_RESET: begin
          next_st.ir_latch = IR_DEF;
        end
        ST_CAP_DR: begin
          next_st.bypass = 1'b0;
          next_st.id_shift = ID_VALUE;
          next_st.bsr_shift = sys_in;
        end
        ST_SHIFT_DR: begin
          // One stage toward TDO per test clock
          if (sel_bsr) begin
            next_st.bsr_shift = {pins.tdi, st.bsr_shift[BSRW-1:1]};
          end else if (sel_id) begin
            next_st.id_shift = {pins.tdi, st.id_shift[31:1]};
          end else begin
            next_st.bypass = pins.tdi;
          end
        end
        ST_UPD_DR: begin
          if (sel_bsr) begin
            next_st.bsr_latch = st.bsr_shift;
          end
        end
        ST_CAP_IR: begin
          next_st.ir_shift = IR_CAP;
        end
        ST_SHIFT_IR: begin
          next_st.ir_shift = {pins.tdi, st.ir_shift[IRW-1:1]};
        end
        ST_UPD_IR: begin
          next_st.ir_latch = st.ir_shift;
        end
        default: begin
          // Pause and exit states hold every shift stage
          next_st.ir_shift = st.ir_shift;
        end
      endcase

      // Default instruction takes effect as the reset state is entered
      if (next_st.state == ST_RESET) begin
        next_st.ir_latch = IR_DEF;
      end
    end

    // Data out moves only on test clock fall; enable only in shift states
    if (tck_fall) begin
      next_st.tdo_oe = (st.state == ST_SHIFT_DR) || (st.state == ST_SHIFT_IR);
      next_st.tdo = (st.state == ST_SHIFT_IR) ? st.ir_shift[0] : dr_out;
    end
    if (!pins.trst_n || st.state == ST_RESET) begin
      next_st.tdo_oe = 1'b0;
    end

    // Boundary pins follow the instruction being registered, never lag it
    next_st.test_active = (next_st.state != ST_RESET) &&
      (next_st.ir_latch == IRW'(INSN_EXTEST));
    next_st.pin_out = next_st.test_active ? next_st.bsr_latch : sys_in;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{
        rst_sync: 2'b00,
        tck_prev: 1'b0,
        state: ST_RESET,
        ir_shift: '0,
        ir_latch: IR_DEF,
        bypass: 1'b0,
        id_shift: '0,
        bsr_shift: '0,
        bsr_latch: '0,
        pin_out: '0,
        tdo: 1'b0,
        tdo_oe: 1'b0,
        test_active: 1'b0
      };
    end else if (!rst_local_n) begin
      st <= '{
        rst_sync: next_st.rst_sync,
        tck_prev: 1'b0,
        state: ST_RESET,
        ir_shift: '0,
        ir_latch: IR_DEF,
        bypass: 1'b0,
        id_shift: '0,
        bsr_shift: '0,
        bsr_latch: '0,
        pin_out: '0,
        tdo: 1'b0,
        tdo_oe: 1'b0,
        test_active: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pin_out;
  assign tdo = st.tdo;
  assign tdo_oe = st.tdo_oe;
  assign cur_insn = st.ir_latch;
  assign test_active = st.test_active;

endmodule

//--- tap_pkg.sv
package tap_pkg;

  localparam int IR_WIDTH = 4;
  localparam int BSR_WIDTH = 8;
  localparam int RESET_TMS_ONES = 5;

  // Instruction codes
  localparam logic [IR_WIDTH-1:0] INSN_EXTEST = 4'h0;
  localparam logic [IR_WIDTH-1:0] INSN_SAMPLE = 4'h1;
  localparam logic [IR_WIDTH-1:0] INSN_IDCODE = 4'h2;
  localparam logic [IR_WIDTH-1:0] INSN_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] INSN_DEFAULT = INSN_IDCODE;
  // Fixed capture pattern: two low bits 01
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;

  // Arbitrary identification value, names no real maker or part
  localparam logic [31:0] ID_VALUE = 32'h1234_5001;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Link pins as sampled into the system clock domain
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_t;

endpackage

//--- tap_sync.sv
module tap_sync
  import tap_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [WIDTH-1:0] din, // Asynchronous inputs
  output logic [WIDTH-1:0] dout // Synchronised copy
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  initial begin
    if (WIDTH < 1) $error("tap_sync WIDTH must be positive");
  end

  always_comb begin
    next_st = st;
    next_st.meta = din;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.sync;

endmodule

//--- tap_assertions.sv
module tap_assertions
  import tap_pkg::*;
#(
  parameter int IRW = IR_WIDTH,
  parameter int BSRW = BSR_WIDTH
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic tck, // Test clock
  input wire logic tms, // Mode select
  input wire logic tdi, // Data in
  input wire logic trst_n, // Test reset
  input wire logic [BSRW-1:0] sys_in, // System values
  input wire logic [BSRW-1:0] pin_out, // Pin values
  input wire logic tdo, // Data out
  input wire logic tdo_oe, // Out enable
  input wire logic [IRW-1:0] cur_insn, // Instruction
  input wire logic test_active // Boundary drive
);
  logic tck_q;
  logic [2:0] ones;
  // Counts test clock rises with mode select high, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tck_q <= 1'b0;
      ones <= 3'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q) begin
        ones <= !tms ? 3'h0 : ((ones == 3'h7) ? ones : ones + 3'h1);
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_five_ones_reset: assert property (ones >= 3'h5 |-> ##6 (cur_insn == INSN_DEFAULT && !test_active))
    else $error("five high mode clocks did not reset");
  a_active_extest: assert property (test_active |-> cur_insn == INSN_EXTEST)
    else $error("boundary drive without extest");
  a_pins_follow: assert property (!test_active && $past(!test_active) |-> pin_out == $past(sys_in))
    else $error("pins do not follow system");
  a_insn_shift_stable: assert property (tdo_oe && $past(tdo_oe) |-> $stable(cur_insn))
    else $error("instruction changed while shifting");
  a_pins_shift_stable: assert property (tdo_oe && test_active && $past(test_active) |-> $stable(pin_out))
    else $error("pins changed while shifting");
  a_trst_default: assert property (!trst_n [*8] |-> cur_insn == INSN_DEFAULT)
    else $error("test reset left instruction");
  a_trst_quiet: assert property (!trst_n [*8] |-> !tdo_oe && !test_active)
    else $error("test reset left output driven");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 3))
    else $error("data out changed off falling edge");
  a_oe_on_fall: assert property ($rose(tdo_oe) |-> !$past(tck, 3))
    else $error("enable rose off falling edge");
endmodule
bind tap_controller tap_assertions #(.IRW(IRW), .BSRW(BSRW)) u_tap_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
  .sys_in(sys_in), .pin_out(pin_out), .tdo(tdo), .tdo_oe(tdo_oe), .cur_insn(cur_insn),
  .test_active(test_active));

//--- tap_probe.sv
module tap_probe (
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Data in
  input wire logic tdo, // Data out
  input wire logic tdo_oe // Out enable
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck = 1'b0; // Clock parked low between frames
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Undriven output reads as the inverse of what it shows
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    #150 q = tdo_oe ? tdo : ~tdo;
    #10 tck = 1'b0;
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], dout[i]);
    end
  endtask
endmodule

//--- boundary_scan_tap_controller_bench.sv
module boundary_scan_tap_controller_bench;
  import tap_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic trst_n = 1'b1;
  logic [7:0] sys_in = 8'h00;
  logic tck, tms, tdi, tdo, tdo_oe, test_active;
  logic [7:0] pin_out;
  logic [3:0] cur_insn;
  logic [31:0] got, val;
  logic [3:0] codes [5] = '{INSN_IDCODE, INSN_SAMPLE, INSN_BYPASS, 4'h7, INSN_EXTEST};
  int n_mismatch = 0;
  int cmp_count = 0;
  always #20 clk_sys = ~clk_sys;
  tap_controller u_tap_controller (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .sys_in(sys_in), .pin_out(pin_out), .tdo(tdo),
    .tdo_oe(tdo_oe), .cur_insn(cur_insn), .test_active(test_active));
  tap_probe u_tap_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bits to shift for an instruction: its data register length, or BSR_WIDTH + 1 for the one-bit bypass path
  function automatic int dr_len(input logic [3:0] code);
    if (code == INSN_IDCODE) begin
      return $bits(ID_VALUE);
    end else if (code == INSN_SAMPLE || code == INSN_EXTEST) begin
      return BSR_WIDTH;
    end
    return BSR_WIDTH + 1;
  endfunction
  task automatic tms_seq(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      u_tap_probe.bit_io(seq[i], 1'b0, q);
    end
  endtask
  // Scan from idle with a pause after split bits, back to idle
  task automatic scan(input bit ir, input int n, input int split, input logic [31:0] din);
    logic [31:0] lo, hi;
    tms_seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    u_tap_probe.shift(split, din, lo);
    tms_seq(8'h04, 4);
    u_tap_probe.shift(n - split, din >> split, hi);
    got = lo | (hi << split);
    tms_seq(8'h01, 2);
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(32'h49cb));
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check("reset insn", cur_insn, INSN_DEFAULT);
    check("reset oe", tdo_oe, 1'b0);
    tms_seq(8'h00, 1);
    $display("Test of reset default done");
    repeat (2) begin
      foreach (codes[i]) begin
        val = $urandom;
        sys_in = val[15:8];
        scan(1'b1, 4, 2, {28'h0, codes[i]});
        check("ir capture", got, 32'h1);
        check("insn", cur_insn, codes[i]);
        check("active", test_active, codes[i] == INSN_EXTEST);
        check("oe idle", tdo_oe, 1'b0);
        scan(1'b0, dr_len(codes[i]), 3, val);
        case (codes[i])
          INSN_IDCODE: check("id", got, ID_VALUE);
          INSN_SAMPLE: check("sample", got[7:0], sys_in);
          INSN_EXTEST: check("pins", pin_out, val[7:0]);
          default: check("bypass", got[8:1], val[7:0]);
        endcase
        $display("Test of code %h done", codes[i]);
      end
    end
    tms_seq(8'h01, 3);
    tms_seq(8'h1f, 5);
    repeat (4) @(posedge clk_sys);
    #1;
    check("ones insn", cur_insn, INSN_DEFAULT);
    check("ones pins", pin_out, sys_in);
    tms_seq(8'h00, 1);
    $display("Test of mode select reset done");
    scan(1'b1, 4, 1, {28'h0, INSN_EXTEST});
    check("ir capture split", got, 32'h1);
    check("extest active", test_active, 1'b1);
    trst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    check("trst insn", cur_insn, INSN_DEFAULT);
    check("trst oe", tdo_oe, 1'b0);
    check("trst active", test_active, 1'b0);
    trst_n = 1'b1;
    $display("Test of test reset done");
    test_done();
  end
endmodule
